// file: rtl/adc_seq_pkg.sv
// Constants, register map and types for the converter sequencer.
// Assumes an 8-bit CPU bus and one 25 MHz clock; one state is one cycle.
package adc_seq_pkg;
    localparam int RES_W = 10;
    localparam int ADDR_W = 4;
    localparam int CNT_W = 9;
    // Byte offsets on the CPU bus
    localparam logic [ADDR_W-1:0] OFS_RES_BASE = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_CSR = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_TRG = 4'h9;
    // Control/status fields
    localparam int CSR_FLAG_BIT = 7;
    localparam int CSR_IE_BIT = 6;
    localparam int CSR_START_BIT = 5;
    localparam int CSR_SCAN_BIT = 4;
    localparam int CSR_SPEED_BIT = 3;
    localparam int CSR_GROUP_BIT = 2;
    localparam logic [7:0] CSR_RESET = 8'h00;
    // Trigger-control fields
    localparam int TRG_EN_BIT = 7;
    localparam logic [7:0] TRG_RESET = 8'h7F;
    localparam logic [6:0] TRG_RSVD = 7'h7F;
    // Conversion timing in states (start delay + sample + ten bit steps)
    localparam logic [CNT_W-1:0] DLY_SLOW = 9'h00B;
    localparam logic [CNT_W-1:0] SMP_SLOW = 9'h040;
    localparam logic [CNT_W-1:0] BIT_SLOW = 9'h013;
    localparam logic [CNT_W-1:0] DLY_FAST = 9'h00B;
    localparam logic [CNT_W-1:0] SMP_FAST = 9'h020;
    localparam logic [CNT_W-1:0] BIT_FAST = 9'h009;
    typedef enum logic [1:0] {SAR_IDLE, SAR_DELAY, SAR_SAMPLE, SAR_CONV}
        sar_state_t;
endpackage

// file: rtl/sar_link_if.sv
// Signals between the sequencer control and the approximation engine.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface sar_link_if;
    import adc_seq_pkg::*;
    logic start;
    logic abort;
    logic speed;
    logic cmp;
    logic done;
    logic sample;
    logic [RES_W-1:0] result;
    logic [RES_W-1:0] dac;
    modport ctrl(output start, abort, speed, cmp,
        input done, sample, result, dac);
    modport core(input start, abort, speed, cmp,
        output done, sample, result, dac);
endinterface
`default_nettype wire

// file: rtl/sar_engine.sv
// Successive approximation engine: delay, sample, then ten bit trials.
// Assumes cmp is already synchronised and high when input exceeds dac.
`timescale 1ns/1ns
`default_nettype none
module sar_engine (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Link to control
    sar_link_if.core lnk
);
    import adc_seq_pkg::*;
    sar_state_t state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [3:0] idx_reg, idx_next;
    logic [RES_W-1:0] code_reg, code_next;
    logic [RES_W-1:0] res_reg, res_next;
    logic fast_reg, fast_next;
    logic smp_reg, smp_next;
    logic done_reg, done_next;
    logic [RES_W-1:0] trial;
    logic [RES_W-1:0] kept;

    // Next state; speed is latched at start so it cannot change mid-way
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        idx_next = idx_reg;
        code_next = code_reg;
        res_next = res_reg;
        fast_next = fast_reg;
        smp_next = smp_reg;
        done_next = 1'b0;
        trial = RES_W'(10'h001 << idx_reg);
        kept = lnk.cmp ? code_reg : (code_reg & ~trial);
        if (cnt_reg != '0) begin
            cnt_next = cnt_reg - 9'h001;
        end
        unique case (state_reg)
            SAR_IDLE: if (lnk.start) begin
                state_next = SAR_DELAY;
                fast_next = lnk.speed;
                // Start register eats one delay state
                cnt_next = (lnk.speed ? DLY_FAST : DLY_SLOW) - 9'h002;
            end
            SAR_DELAY: if (cnt_reg == '0) begin
                state_next = SAR_SAMPLE;
                smp_next = 1'b1;
                cnt_next = (fast_reg ? SMP_FAST : SMP_SLOW) - 9'h001;
            end
            SAR_SAMPLE: if (cnt_reg == '0) begin
                state_next = SAR_CONV;
                smp_next = 1'b0;
                idx_next = 4'h9;
                code_next = 10'h200;
                cnt_next = (fast_reg ? BIT_FAST : BIT_SLOW) - 9'h001;
            end
            SAR_CONV: if (cnt_reg == '0) begin
                // Keep or drop the trial bit, then try the next one
                if (idx_reg == 4'h0) begin
                    res_next = kept;
                    done_next = 1'b1;
                    state_next = SAR_IDLE;
                end else begin
                    idx_next = idx_reg - 4'h1;
                    code_next = kept | RES_W'(10'h001 << (idx_reg - 4'h1));
                    cnt_next = (fast_reg ? BIT_FAST : BIT_SLOW) - 9'h001;
                end
            end
        endcase
        if (lnk.abort) begin
            state_next = SAR_IDLE;
            smp_next = 1'b0;
            done_next = 1'b0;
        end
    end

    // State registers
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_reg <= SAR_IDLE;
            cnt_reg <= '0;
            idx_reg <= 4'h0;
            code_reg <= '0;
            res_reg <= '0;
            fast_reg <= 1'b0;
            smp_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            idx_reg <= idx_next;
            code_reg <= code_next;
            res_reg <= res_next;
            fast_reg <= fast_next;
            smp_reg <= smp_next;
            done_reg <= done_next;
        end
    end

    assign lnk.done = done_reg;
    assign lnk.sample = smp_reg;
    assign lnk.result = res_reg;
    assign lnk.dac = code_reg;
endmodule // sar_engine
`default_nettype wire

// file: rtl/adc_seq_ctrl.sv
// Top of the converter sequencer: CPU byte registers, mode sequencing.
// Assumes an 8-bit CPU bus on i_clk and a comparator from the analog core.
`timescale 1ns/1ns
`default_nettype none
module adc_seq_ctrl (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // CPU byte bus
    input wire logic [adc_seq_pkg::ADDR_W-1:0] i_bus_addr,
    input wire logic i_bus_rd,
    input wire logic i_bus_wr,
    input wire logic [7:0] i_bus_wdata,
    output logic [7:0] o_bus_rdata,
    // Timer trigger, one-cycle pulse
    input wire logic i_timer_trigger_source,
    // Analog core
    input wire logic i_cmp_above,
    output logic o_sample_hold,
    output logic [adc_seq_pkg::RES_W-1:0] o_dac_code,
    output logic [2:0] o_analog_sel,
    // Interrupt request
    output logic o_conv_end_irq
);
    import adc_seq_pkg::*;

    sar_link_if lnk();

    logic cmp_meta_reg, cmp_sync_reg;
    logic conv_end_flag_reg, conv_end_flag_next;
    logic end_irq_enable_reg, end_irq_enable_next;
    logic conv_start_bit_reg, conv_start_bit_next;
    logic scan_reg, scan_next;
    logic conv_speed_sel_reg, conv_speed_sel_next;
    logic [2:0] chan_reg, chan_next;
    logic timer_start_enable_reg, timer_start_enable_next;
    logic armed_reg, armed_next;
    logic [1:0] pos_reg, pos_next;
    logic [2:0] sel_reg, sel_next;
    logic go_reg, go_next;
    logic abort_reg, abort_next;
    logic irq_reg, irq_next;
    logic [RES_W-1:0] res_reg [4];
    logic [RES_W-1:0] res_next [4];
    logic [7:0] rdata_reg, rdata_next;
    logic [7:0] hold_reg, hold_next;
    logic wr_csr, rd_csr, wr_trg, rd_res;
    logic flag_set;
    logic [1:0] ridx;
    logic [1:0] last_pos;

    // Decode of the byte bus
    assign wr_csr = i_bus_wr && (i_bus_addr == OFS_CSR);
    assign rd_csr = i_bus_rd && (i_bus_addr == OFS_CSR);
    assign wr_trg = i_bus_wr && (i_bus_addr == OFS_TRG);
    assign rd_res = i_bus_rd && (i_bus_addr[3] == OFS_RES_BASE[3]);
    assign ridx = i_bus_addr[2:1];
    assign last_pos = chan_reg[1:0];

    // Comparator comes from the analog domain, so two flops first
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cmp_meta_reg <= 1'b0;
            cmp_sync_reg <= 1'b0;
        end else begin
            cmp_meta_reg <= i_cmp_above;
            cmp_sync_reg <= cmp_meta_reg;
        end
    end

    // Engine link
    assign lnk.start = go_reg;
    assign lnk.abort = abort_reg;
    assign lnk.speed = conv_speed_sel_reg;
    assign lnk.cmp = cmp_sync_reg;

    sar_engine u_sar (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .lnk(lnk.core)
    );

    // Control and sequencing next values
    always_comb begin
        conv_end_flag_next = conv_end_flag_reg;
        end_irq_enable_next = end_irq_enable_reg;
        conv_start_bit_next = conv_start_bit_reg;
        scan_next = scan_reg;
        conv_speed_sel_next = conv_speed_sel_reg;
        chan_next = chan_reg;
        timer_start_enable_next = timer_start_enable_reg;
        armed_next = armed_reg;
        pos_next = pos_reg;
        sel_next = sel_reg;
        go_next = 1'b0;
        abort_next = 1'b0;
        flag_set = 1'b0;
        for (int i = 0; i < 4; i++) begin
            res_next[i] = res_reg[i];
        end
        // Settings take effect in the same write as the start bit
        if (wr_csr) begin
            end_irq_enable_next = i_bus_wdata[CSR_IE_BIT];
            scan_next = i_bus_wdata[CSR_SCAN_BIT];
            conv_speed_sel_next = i_bus_wdata[CSR_SPEED_BIT];
            chan_next = i_bus_wdata[2:0];
            conv_start_bit_next = i_bus_wdata[CSR_START_BIT];
        end
        if (wr_trg) begin
            timer_start_enable_next = i_bus_wdata[TRG_EN_BIT];
        end
        // Timer start only when enabled and halted
        if (i_timer_trigger_source && timer_start_enable_reg
            && !conv_start_bit_reg) begin
            conv_start_bit_next = 1'b1;
        end
        // Completion of one conversion
        if (lnk.done && conv_start_bit_reg) begin
            res_next[sel_reg[1:0]] = lnk.result;
            if (!scan_reg) begin
                flag_set = 1'b1;
                conv_start_bit_next = 1'b0;
            end else begin
                if (pos_reg == last_pos) begin
                    flag_set = 1'b1;
                    pos_next = 2'b00;
                end else begin
                    pos_next = pos_reg + 2'b01;
                end
                sel_next = {chan_reg[CSR_GROUP_BIT], pos_next};
                go_next = conv_start_bit_next;
            end
        end
        // Fresh start: new settings, first channel of the group in scan
        if (!conv_start_bit_reg && conv_start_bit_next) begin
            pos_next = 2'b00;
            sel_next = scan_next ? {chan_next[CSR_GROUP_BIT], 2'b00}
                : chan_next;
            go_next = 1'b1;
        end
        // Software stop halts a running conversion
        if (conv_start_bit_reg && !conv_start_bit_next && !flag_set) begin
            abort_next = 1'b1;
            go_next = 1'b0;
        end
        // Flag: clear needs an earlier read while set; set wins
        if (rd_csr && conv_end_flag_reg) begin
            armed_next = 1'b1;
        end
        if (wr_csr && !i_bus_wdata[CSR_FLAG_BIT] && armed_reg) begin
            conv_end_flag_next = 1'b0;
            armed_next = 1'b0;
        end
        if (flag_set) begin
            conv_end_flag_next = 1'b1;
        end
        irq_next = conv_end_flag_next && end_irq_enable_next;
    end

    // Control registers; all zero from reset, trigger gate included
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            conv_end_flag_reg <= CSR_RESET[CSR_FLAG_BIT];
            end_irq_enable_reg <= CSR_RESET[CSR_IE_BIT];
            conv_start_bit_reg <= CSR_RESET[CSR_START_BIT];
            scan_reg <= CSR_RESET[CSR_SCAN_BIT];
            conv_speed_sel_reg <= CSR_RESET[CSR_SPEED_BIT];
            chan_reg <= CSR_RESET[2:0];
            timer_start_enable_reg <= TRG_RESET[TRG_EN_BIT];
            armed_reg <= 1'b0;
            pos_reg <= 2'b00;
            sel_reg <= 3'h0;
            go_reg <= 1'b0;
            abort_reg <= 1'b0;
            irq_reg <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                res_reg[i] <= '0;
            end
        end else begin
            conv_end_flag_reg <= conv_end_flag_next;
            end_irq_enable_reg <= end_irq_enable_next;
            conv_start_bit_reg <= conv_start_bit_next;
            scan_reg <= scan_next;
            conv_speed_sel_reg <= conv_speed_sel_next;
            chan_reg <= chan_next;
            timer_start_enable_reg <= timer_start_enable_next;
            armed_reg <= armed_next;
            pos_reg <= pos_next;
            sel_reg <= sel_next;
            go_reg <= go_next;
            abort_reg <= abort_next;
            irq_reg <= irq_next;
            for (int i = 0; i < 4; i++) begin
                res_reg[i] <= res_next[i];
            end
        end
    end

    // Read path; the latch keeps word reads coherent across two bytes
    always_comb begin
        rdata_next = 8'h00;
        hold_next = hold_reg;
        if (rd_res && !i_bus_addr[0]) begin
            rdata_next = res_reg[ridx][RES_W-1:2];
            hold_next = {res_reg[ridx][1:0], 6'h00};
        end else if (rd_res) begin
            rdata_next = hold_reg;
        end else if (rd_csr) begin
            rdata_next = {conv_end_flag_reg, end_irq_enable_reg,
                conv_start_bit_reg, scan_reg, conv_speed_sel_reg, chan_reg};
        end else if (i_bus_rd && i_bus_addr == OFS_TRG) begin
            rdata_next = {timer_start_enable_reg, TRG_RSVD};
        end
    end

    // Read registers
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rdata_reg <= 8'h00;
            hold_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
            hold_reg <= hold_next;
        end
    end

    // Outputs, each from a flop
    assign o_bus_rdata = rdata_reg;
    assign o_conv_end_irq = irq_reg;
    assign o_analog_sel = sel_reg;
    assign o_sample_hold = lnk.sample;
    assign o_dac_code = lnk.dac;

    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    single_end_a: assert property (lnk.done && conv_start_bit_reg && !scan_reg
        |=> conv_end_flag_reg && !conv_start_bit_reg)
        else $error("single completion did not set flag and stop");
    flag_one_a: assert property (wr_csr && i_bus_wdata[CSR_FLAG_BIT]
        && !conv_end_flag_reg && !flag_set |=> !conv_end_flag_reg)
        else $error("writing one set the end flag");
    irq_gate_a: assert property ((conv_end_flag_reg && end_irq_enable_reg)
        ##1 (conv_end_flag_reg && end_irq_enable_reg)
        |-> o_conv_end_irq)
        else $error("interrupt missing while flag and enable high");
    trig_start_a: assert property (i_timer_trigger_source
        && timer_start_enable_reg && !conv_start_bit_reg
        |=> conv_start_bit_reg && go_reg)
        else $error("timer trigger did not start conversion");
    trig_gate_a: assert property (!timer_start_enable_reg && !wr_csr
        && !conv_start_bit_reg |=> !conv_start_bit_reg)
        else $error("trigger started conversion while gated");
    hold_copy_a: assert property (rd_res && !i_bus_addr[0]
        |=> hold_reg[5:0] == 6'h00
        && hold_reg[7:6] == $past(res_reg[ridx][1:0]))
        else $error("upper read did not fill holding latch");
    scan_wrap_a: assert property (lnk.done && conv_start_bit_reg && scan_reg
        && pos_reg == last_pos |=> pos_reg == 2'b00
        && conv_end_flag_reg)
        else $error("scan round did not wrap and flag");
    no_restart_a: assert property (conv_start_bit_reg && !lnk.done
        |=> !go_reg)
        else $error("conversion restarted while running");
    trg_read_a: assert property (i_bus_rd && i_bus_addr == OFS_TRG
        |=> o_bus_rdata[6:0] == 7'h7F)
        else $error("reserved trigger bits not read as one");

    single_cov: cover property (lnk.done && !scan_reg);
    scan_cov: cover property (lnk.done && scan_reg && pos_reg == last_pos);
    trig_cov: cover property (i_timer_trigger_source
        && timer_start_enable_reg && !conv_start_bit_reg);
endmodule // adc_seq_ctrl
`default_nettype wire

// file: dv/analog_model.sv
// Analog front end model: one sample-and-hold plus comparator on the selected input.
// Assumes levels come from the bench and the sequencer syncs the output.
`timescale 1ns/1ns
`default_nettype none
module analog_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // From the sequencer
    input wire logic i_sample_hold,
    input wire logic [adc_seq_pkg::RES_W-1:0] i_dac_code,
    input wire logic [2:0] i_analog_sel,
    // Analog levels set by the bench
    input wire logic [7:0][adc_seq_pkg::RES_W-1:0] i_levels,
    // To the sequencer
    output logic o_cmp_above
);
    import adc_seq_pkg::*;
    logic [RES_W-1:0] held_reg;
    // Track selected input while sampling, hold it afterwards
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            held_reg <= '0;
        end else if (i_sample_hold) begin
            held_reg <= i_levels[i_analog_sel];
        end
    end
    // Half-LSB offset so the ideal code equals the level exactly
    assign o_cmp_above = {held_reg, 1'b1} > {i_dac_code, 1'b0};
endmodule // analog_model
`default_nettype wire

// file: dv/tb.sv
// Self-checking bench for the converter sequencer over its byte bus.
// Assumes the design package and an analog model on the comparator side.
`timescale 1ns/1ns
`default_nettype none
module tb;
    import adc_seq_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [ADDR_W-1:0] bus_addr = 4'h0;
    logic bus_rd = 1'b0;
    logic bus_wr = 1'b0;
    logic [7:0] bus_wdata = 8'h00;
    logic trig = 1'b0;
    logic [7:0] bus_rdata;
    logic cmp_above;
    logic sample_hold;
    logic irq;
    logic [RES_W-1:0] dac_code;
    logic [2:0] analog_sel;
    logic [7:0][RES_W-1:0] levels;
    logic [7:0] rd_val;
    logic [RES_W-1:0] d_old;
    int failures = 0;
    int compares = 0;
    int cyc = 0;
    int t0 = 0;
    int t1 = 0;
    adc_seq_ctrl i_dut (.i_clk(clk), .i_reset_n(reset_n),
        .i_bus_addr(bus_addr), .i_bus_rd(bus_rd), .i_bus_wr(bus_wr),
        .i_bus_wdata(bus_wdata), .o_bus_rdata(bus_rdata),
        .i_timer_trigger_source(trig), .i_cmp_above(cmp_above),
        .o_sample_hold(sample_hold), .o_dac_code(dac_code),
        .o_analog_sel(analog_sel), .o_conv_end_irq(irq));
    analog_model i_model (.i_clk(clk), .i_reset_n(reset_n),
        .i_sample_hold(sample_hold), .i_dac_code(dac_code),
        .i_analog_sel(analog_sel), .i_levels(levels),
        .o_cmp_above(cmp_above));
    // Free-running clock and cycle count for latency checks
    always #20 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    task automatic give_verdict();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
        input string what);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time,
                what, seen, exp);
        end
    endtask
    // Strobes rise and fall on falling edges, taken at the rising edge
    task automatic bus_write(input logic [3:0] addr, input logic [7:0] data);
        @(negedge clk);
        bus_addr = addr;
        bus_wdata = data;
        bus_wr = 1'b1;
        @(negedge clk);
        bus_wr = 1'b0;
        t0 = cyc;
    endtask
    task automatic bus_read(input logic [3:0] addr);
        @(negedge clk);
        bus_addr = addr;
        bus_rd = 1'b1;
        @(negedge clk);
        bus_rd = 1'b0;
        rd_val = bus_rdata;
    endtask
    task automatic read_check(input logic [3:0] addr, input logic [7:0] exp,
        input string what);
        bus_read(addr);
        check(16'(rd_val), 16'(exp), what);
    endtask
    task automatic pulse_trigger();
        @(negedge clk);
        trig = 1'b1;
        @(negedge clk);
        trig = 1'b0;
        t0 = cyc;
    endtask
    // Bounded wait; irq rises on the same edge as the flag
    task automatic wait_irq(input int limit);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < limit) begin
            @(negedge clk);
            n++;
        end
    endtask
    // Upper byte first so the holding latch is fresh
    task automatic res_check(input logic [1:0] pos, input logic [9:0] r);
        logic [3:0] a;
        a = OFS_RES_BASE + {1'b0, pos, 1'b0};
        read_check(a, r[9:2], "result upper");
        read_check(a + 4'h1, {r[1:0], 6'h00}, "result lower");
    endtask
    task automatic single_conv(input logic [2:0] ch, input logic fast);
        bus_write(OFS_CSR, {3'b011, 1'b0, fast, ch});
        read_check(OFS_CSR, {3'b011, 1'b0, fast, ch}, "start held");
        check(16'(analog_sel), 16'(ch), "input select");
        wait_irq(400);
        check(16'(cyc - t0), fast ? 16'h0086 : 16'h010A, "time");
        read_check(OFS_CSR, {3'b110, 1'b0, fast, ch}, "done");
        res_check(ch[1:0], levels[ch]);
        bus_write(OFS_CSR, 8'h40);
        read_check(OFS_CSR, 8'h40, "flag cleared");
        check(16'(irq), 16'h0000, "irq dropped");
    endtask
    // Watchdog sized well past the longest sequence
    initial begin
        #(20000 * 40);
        failures++;
        give_verdict();
    end
    initial begin
        for (int i = 0; i < 8; i++) levels[i] = 10'(10'h05A + 10'h07D * i);
        repeat (3) @(negedge clk);
        reset_n = 1'b1;
        read_check(OFS_CSR, CSR_RESET, "csr reset");
        read_check(OFS_TRG, 8'h7F, "trigger reset");
        bus_write(OFS_RES_BASE, 8'h55);
        res_check(2'h0, 10'h000);
        read_check(4'hC, 8'h00, "unmapped");
        check(16'(irq), 16'h0000, "irq idle");
        $display("test reset done");
        for (int c = 0; c < 8; c++) single_conv(3'(c), c[0]);
        $display("test single channels done");
        // Trigger gating, retrigger immunity, flag clearing protocol
        bus_write(OFS_CSR, 8'h4B);
        pulse_trigger();
        read_check(OFS_CSR, 8'h4B, "trigger gated off");
        bus_write(OFS_TRG, 8'h80);
        read_check(OFS_TRG, 8'hFF, "trigger enabled");
        pulse_trigger();
        t1 = t0;
        repeat (40) @(negedge clk);
        pulse_trigger();
        bus_write(OFS_CSR, 8'h6B);
        wait_irq(400);
        check(16'(cyc - t1), 16'h0086, "trigger time");
        bus_write(OFS_CSR, 8'h4B);
        @(negedge clk);
        check(16'(irq), 16'h0001, "unarmed clear");
        read_check(OFS_CSR, 8'hCB, "flag kept");
        bus_write(OFS_CSR, 8'h8B);
        read_check(OFS_CSR, 8'h8B, "write one ignored");
        check(16'(irq), 16'h0000, "irq masked");
        bus_write(OFS_CSR, 8'hCB);
        @(negedge clk);
        check(16'(irq), 16'h0001, "irq unmasked");
        bus_write(OFS_CSR, 8'h4B);
        read_check(OFS_CSR, 8'h4B, "armed clear");
        bus_write(OFS_TRG, 8'h00);
        $display("test trigger done");
        // Scan group 1, three inputs, two rounds then stop
        d_old = levels[3];
        for (int i = 0; i < 8; i++) levels[i] = levels[i] + 10'h011;
        bus_write(OFS_CSR, 8'h7E);
        wait_irq(600);
        read_check(OFS_CSR, 8'hFE, "scan flag");
        check(16'(analog_sel), 16'h0004, "wrap first");
        for (int p = 0; p < 3; p++) res_check(2'(p), levels[4 + p]);
        res_check(2'h3, d_old);
        bus_write(OFS_CSR, 8'h7E);
        @(negedge clk);
        check(16'(irq), 16'h0000, "scan flag clear");
        wait_irq(600);
        read_check(OFS_CSR, 8'hFE, "second round");
        bus_write(OFS_CSR, 8'h5E);
        repeat (450) @(negedge clk);
        read_check(OFS_CSR, 8'h5E, "scan stopped");
        check(16'(irq), 16'h0000, "no flag after stop");
        $display("test scan done");
        give_verdict();
    end
endmodule // tb
`default_nettype wire
